/* File: design/buck_code_decoder.sv */
`timescale 1ns/100ps
`include "buck_vsel_defines.svh"

module buck_code_decoder (
    // Voltage code in
    input  wire logic [5:0]  code,
    // Target voltage out
    output logic      [11:0] millivolts
);

    // ****************************************
    // Common voltage table
    // ****************************************

    // Three linear segments instead of a 64-entry table
    function automatic logic [11:0] code_to_mv(input logic [5:0] c);
        logic [11:0] wide;
        logic [11:0] res;
        wide = {6'h00, c};
        if (c < `VT_FINE_LIMIT) begin
            res = 12'(`VT_FINE_BASE_MV + `VT_FINE_STEP_MV * wide);
        end else if (c < `VT_MID_LIMIT) begin
            res = 12'(`VT_MID_BASE_MV
                      + `VT_MID_STEP_MV * (wide - {6'h00, `VT_FINE_LIMIT}));
        end else begin
            res = 12'(`VT_TOP_BASE_MV
                      + `VT_TOP_STEP_MV * (wide - {6'h00, `VT_MID_LIMIT}));
        end
        return res;
    endfunction

    assign millivolts = code_to_mv(code);

endmodule // buck_code_decoder

/* File: design/buck_voltage_select_regs.sv */
`timescale 1ns/100ps
`include "buck_vsel_defines.svh"

module buck_voltage_select_regs #(
    parameter logic [5:0] BUCK1_DEFAULT      = `RST_BUCK1_CODE,
    parameter logic [5:0] BUCK2_LOW_DEFAULT  = `RST_BUCK2_LOW_CODE,
    parameter logic [5:0] BUCK2_HIGH_DEFAULT = `RST_BUCK2_HIGH_CODE,
    parameter logic [5:0] BUCK3_LOW_DEFAULT  = `RST_BUCK3_LOW_CODE,
    parameter logic [5:0] BUCK3_HIGH_DEFAULT = `RST_BUCK3_HIGH_CODE
) (
    // Clock and reset
    input  wire logic                         mclk,
    input  wire logic                         rst,
    // Register access from the serial interface engine
    input  wire buck_vsel_pkg::reg_req_t      reg_req,
    output buck_vsel_pkg::reg_rsp_t           reg_rsp,
    // Asynchronous inputs from pins and analog
    input  wire logic                         undervoltage_lockout,
    input  wire logic                         buck2_select_pin,
    input  wire logic                         buck3_select_pin,
    // Nonvolatile configuration bits
    input  wire logic                         nv_buck1_external_adjust,
    input  wire logic                         nv_buck2_external_adjust,
    input  wire logic                         nv_buck3_external_adjust,
    // Tracking control from the regulator 2 register
    input  wire logic                         regulator2_follow_enable,
    // Converter settings
    output buck_vsel_pkg::buck_setting_t      first_buck,
    output buck_vsel_pkg::buck_setting_t      second_buck,
    output buck_vsel_pkg::buck_setting_t      third_buck,
    output logic                        [5:0] regulator2_follow_code,
    output logic                              regulator2_follow_active
);
    import buck_vsel_pkg::*;

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic [2:0] sync_c;
    logic [2:0] in_level;   // [0] lockout, [1] buck2 select, [2] buck3 select
    logic       load_pending;

    // Three stages; a level counts once stages two and three agree
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sync_a <= 3'h0;
            sync_b <= 3'h0;
            sync_c <= 3'h0;
        end else begin
            sync_a <= {buck3_select_pin, buck2_select_pin, undervoltage_lockout};
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    // Accepted levels; a disagreeing bit keeps its old value
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            in_level <= 3'h0;
        end else begin
            in_level <= (sync_b & sync_c) | (in_level & (sync_b ^ sync_c));
        end
    end

    // ****************************************
    // Decode of requests and pin events
    // ****************************************
    wire logic [2:0] next_level   = (sync_b & sync_c) | (in_level & (sync_b ^ sync_c));
    wire logic       lockout      = in_level[0];
    wire logic       sel2         = in_level[1];
    wire logic       sel3         = in_level[2];
    wire logic       sel2_edge    = next_level[1] ^ in_level[1];
    wire logic       sel3_edge    = next_level[2] ^ in_level[2];
    // Defaults load once after reset and for as long as lockout lasts
    wire logic       load_default = load_pending | lockout;
    wire logic       wr_ok        = reg_req.wr & ~load_default;
    wire logic       wr_b1        = wr_ok & (reg_req.addr == `ADDR_BUCK1_VOLTAGE);
    wire logic       wr_b2l       = wr_ok & (reg_req.addr == `ADDR_BUCK2_VOLTAGE_LOW);
    wire logic       wr_b2h       = wr_ok & (reg_req.addr == `ADDR_BUCK2_VOLTAGE_HIGH);
    wire logic       wr_b3l       = wr_ok & (reg_req.addr == `ADDR_BUCK3_VOLTAGE_LOW);
    wire logic       wr_b3h       = wr_ok & (reg_req.addr == `ADDR_BUCK3_VOLTAGE_HIGH);
    wire logic [5:0] wr_code      = reg_req.wdata[`FLD_CODE_MSB:`FLD_CODE_LSB];
    wire logic       wr_ext       = reg_req.wdata[`FLD_EXT_ADJUST];

    // ****************************************
    // Voltage registers
    // ****************************************
    logic       b1_ext;
    logic [5:0] b1_code;
    logic [5:0] b2l_code;
    logic       b2h_ext;
    logic [5:0] b2h_code;
    logic [5:0] b3l_code;
    logic       b3h_ext;
    logic [5:0] b3h_code;

    // Reset takes constants only; the nonvolatile bits arrive one edge later
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            load_pending <= 1'b1;
        end else begin
            load_pending <= 1'b0;
        end
    end

    // Bit 6 and low-register bits 7..6 are not stored at all
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            b1_ext   <= 1'b0;
            b1_code  <= BUCK1_DEFAULT;
            b2l_code <= BUCK2_LOW_DEFAULT;
            b2h_ext  <= 1'b0;
            b2h_code <= BUCK2_HIGH_DEFAULT;
            b3l_code <= BUCK3_LOW_DEFAULT;
            b3h_ext  <= 1'b0;
            b3h_code <= BUCK3_HIGH_DEFAULT;
        end else if (load_default) begin
            b1_ext   <= nv_buck1_external_adjust;
            b1_code  <= BUCK1_DEFAULT;
            b2l_code <= BUCK2_LOW_DEFAULT;
            b2h_ext  <= nv_buck2_external_adjust;
            b2h_code <= BUCK2_HIGH_DEFAULT;
            b3l_code <= BUCK3_LOW_DEFAULT;
            b3h_ext  <= nv_buck3_external_adjust;
            b3h_code <= BUCK3_HIGH_DEFAULT;
        end else begin
            if (wr_b1) begin
                b1_ext  <= wr_ext;
                b1_code <= wr_code;
            end
            if (wr_b2l) begin
                b2l_code <= wr_code;
            end
            if (wr_b2h) begin
                b2h_ext  <= wr_ext;
                b2h_code <= wr_code;
            end
            if (wr_b3l) begin
                b3l_code <= wr_code;
            end
            if (wr_b3h) begin
                b3h_ext  <= wr_ext;
                b3h_code <= wr_code;
            end
        end
    end

    // ****************************************
    // Read-back
    // ****************************************
    wire logic [7:0] rd_mux =
        (reg_req.addr == `ADDR_BUCK1_VOLTAGE)      ? {b1_ext, 1'b0, b1_code}  :
        (reg_req.addr == `ADDR_BUCK2_VOLTAGE_LOW)  ? {2'b00, b2l_code}        :
        (reg_req.addr == `ADDR_BUCK2_VOLTAGE_HIGH) ? {b2h_ext, 1'b0, b2h_code} :
        (reg_req.addr == `ADDR_BUCK3_VOLTAGE_LOW)  ? {2'b00, b3l_code}        :
        (reg_req.addr == `ADDR_BUCK3_VOLTAGE_HIGH) ? {b3h_ext, 1'b0, b3h_code} :
        8'h00;

    // Answer one edge after the request; unmapped offsets read zero
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reg_rsp <= '0;
        end else begin
            reg_rsp.valid <= reg_req.rd;
            reg_rsp.data  <= reg_req.rd ? rd_mux : 8'h00;
        end
    end

    // ****************************************
    // Active code selection and decode
    // ****************************************
    wire logic [5:0]  act2_code = sel2 ? b2h_code : b2l_code;
    wire logic [5:0]  act3_code = sel3 ? b3h_code : b3l_code;
    wire logic [11:0] mv1;
    wire logic [11:0] mv2;
    wire logic [11:0] mv3;

    // One table shared by all three converters
    buck_code_decoder u_dec1 (
        .code       (b1_code),
        .millivolts (mv1)
    );
    buck_code_decoder u_dec2 (
        .code       (act2_code),
        .millivolts (mv2)
    );
    buck_code_decoder u_dec3 (
        .code       (act3_code),
        .millivolts (mv3)
    );

    // Any write to a converter's pair restarts its ramp, even if inactive
    wire logic start2 = wr_b2l | wr_b2h | sel2_edge;
    wire logic start3 = wr_b3l | wr_b3h | sel3_edge;

    // Ramp starts wait one edge, so each pulse leaves together with the new code;
    // otherwise a converter latching on the pulse would still take the old target
    logic [2:0] start_q;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            start_q <= 3'h0;
        end else begin
            start_q <= {start3, start2, wr_b1};
        end
    end

    // ****************************************
    // Registered outputs
    // ****************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            first_buck  <= '0;
            second_buck <= '0;
            third_buck  <= '0;
        end else begin
            first_buck  <= '{b1_ext, b1_code, mv1, start_q[0]};
            second_buck <= '{b2h_ext, act2_code, mv2, start_q[1]};
            third_buck  <= '{b3h_ext, act3_code, mv3, start_q[2]};
        end
    end

    // Regulator 2 follows whichever third-converter register is selected
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            regulator2_follow_code   <= 6'h00;
            regulator2_follow_active <= 1'b0;
        end else begin
            regulator2_follow_code   <= regulator2_follow_enable ? act3_code : 6'h00;
            regulator2_follow_active <= regulator2_follow_enable;
        end
    end

endmodule // buck_voltage_select_regs

/* File: design/buck_vsel_defines.svh */
`ifndef BUCK_VSEL_DEFINES_SVH
`define BUCK_VSEL_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define ADDR_BUCK1_VOLTAGE      8'h10
`define ADDR_BUCK2_VOLTAGE_LOW  8'h11
`define ADDR_BUCK2_VOLTAGE_HIGH 8'h12
`define ADDR_BUCK3_VOLTAGE_LOW  8'h13
`define ADDR_BUCK3_VOLTAGE_HIGH 8'h14

// ****************************************
// Field positions
// ****************************************
`define FLD_EXT_ADJUST          7
`define FLD_CODE_MSB            5
`define FLD_CODE_LSB            0

// ****************************************
// Default voltage codes after lockout
// ****************************************
`define RST_BUCK1_CODE          6'h3f
`define RST_BUCK2_LOW_CODE      6'h25
`define RST_BUCK2_HIGH_CODE     6'h3f
`define RST_BUCK3_LOW_CODE      6'h0b
`define RST_BUCK3_HIGH_CODE     6'h13

// ****************************************
// Voltage table segments, millivolts
// ****************************************
`define VT_FINE_LIMIT           6'h20
`define VT_MID_LIMIT            6'h3c
`define VT_FINE_BASE_MV         12'h2d5
`define VT_FINE_STEP_MV         12'h019
`define VT_MID_BASE_MV          12'h60e
`define VT_MID_STEP_MV          12'h032
`define VT_TOP_BASE_MV          12'hbb8
`define VT_TOP_STEP_MV          12'h064

`endif

/* File: design/buck_vsel_pkg.sv */
package buck_vsel_pkg;

    // Register access request from the serial interface engine
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // Read answer
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } reg_rsp_t;

    // Setting handed to one converter
    typedef struct packed {
        logic        ext_adjust;
        logic [5:0]  code;
        logic [11:0] millivolts;
        logic        change_start;
    } buck_setting_t;

endpackage

/* File: verif/buck_vsel_sva.sv */
`timescale 1ns/100ps
module buck_vsel_sva (
    // Clock and reset
    input wire logic                         mclk,
    input wire logic                         rst,
    // Register port
    input wire buck_vsel_pkg::reg_req_t      reg_req,
    input wire buck_vsel_pkg::reg_rsp_t      reg_rsp,
    // Pins and settings
    input wire logic                         undervoltage_lockout,
    input wire logic                         buck2_select_pin,
    input wire logic                         buck3_select_pin,
    input wire logic                         regulator2_follow_enable,
    input wire buck_vsel_pkg::buck_setting_t first_buck,
    input wire buck_vsel_pkg::buck_setting_t second_buck,
    input wire buck_vsel_pkg::buck_setting_t third_buck,
    input wire logic [5:0]                   regulator2_follow_code,
    input wire logic                         regulator2_follow_active
);
    import buck_vsel_pkg::*;
    // ****************************************
    // Register port and converter checks
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Requests as seen at the port
    sequence s_rd_low;
        reg_req.rd && (reg_req.addr == 8'h11 || reg_req.addr == 8'h13);
    endsequence
    sequence s_wr_first;
        reg_req.wr && reg_req.addr == 8'h10 && !undervoltage_lockout;
    endsequence
    rd_answer_a: assert property (reg_req.rd |=> reg_rsp.valid) else $error("read not answered");
    idle_data_a: assert property (!reg_rsp.valid |-> reg_rsp.data == 8'h00) else $error("idle data");
    bit6_zero_a: assert property (reg_rsp.valid |-> !reg_rsp.data[6]) else $error("bit 6 set");
    low_bits_a: assert property (s_rd_low |=> reg_rsp.data[7:6] == 2'b00) else $error("low bits");
    unmapped_zero_a: assert property (reg_req.rd && (reg_req.addr < 8'h10 || reg_req.addr > 8'h14)
        |=> reg_rsp.data == 8'h00) else $error("unmapped read not zero");
    write_ramp_a: assert property (s_wr_first |-> ##2 first_buck.change_start)
        else $error("no ramp start after write");
    pin2_ramp_a: assert property ($rose(buck2_select_pin) && !undervoltage_lockout
        |-> ##[2:5] second_buck.change_start) else $error("no ramp on pin edge");
    pin3_ramp_a: assert property ($fell(buck3_select_pin) && !undervoltage_lockout
        |-> ##[2:5] third_buck.change_start) else $error("no ramp on pin edge");
    follow_off_a: assert property (!regulator2_follow_active |-> regulator2_follow_code == 6'h00)
        else $error("follow code while off");
    follow_copy_a: assert property (regulator2_follow_active == $past(regulator2_follow_enable))
        else $error("follow flag lag");
endmodule // buck_vsel_sva

/* File: verif/host_model.sv */
`timescale 1ns/100ps
module host_model (
    // Clock
    input wire logic                    mclk,
    // Register port
    input wire buck_vsel_pkg::reg_rsp_t reg_rsp,
    output buck_vsel_pkg::reg_req_t     reg_req
);
    import buck_vsel_pkg::*;
    // ****************************************
    // Host bus tasks
    // ****************************************
    initial reg_req = '0;
    // One-cycle strobe, launched and dropped on falling edges
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk) reg_req <= '{1'b1, 1'b0, a, d};
        @(negedge mclk) reg_req <= '0;
    endtask
    // Answer is registered, so it is settled by the next falling edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk) reg_req <= '{1'b0, 1'b1, a, 8'h00};
        @(negedge mclk) reg_req <= '0;
        d = reg_rsp.data;
    endtask
endmodule // host_model

/* File: verif/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    import buck_vsel_pkg::*;
    // ****************************************
    // Signals and instances
    // ****************************************
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] r;} row_t;
    logic          mclk = 1'b0;
    logic          rst = 1'b1;
    logic          undervoltage_lockout = 1'b0;
    logic          buck2_select_pin = 1'b0;
    logic          buck3_select_pin = 1'b0;
    logic          regulator2_follow_enable = 1'b0;
    logic          nv_adj2 = 1'b0;
    reg_req_t      reg_req;
    reg_rsp_t      reg_rsp;
    buck_setting_t first_buck, second_buck, third_buck;
    logic [5:0]    regulator2_follow_code;
    logic          regulator2_follow_active;
    logic [7:0]    rdat;
    int            n_errors = 0, compares = 0, cyc = 0;
    logic [7:0]    dflt [5] = '{8'hbf, 8'h25, 8'h3f, 8'h0b, 8'h93};
    // Write data, expected readback; bit 6 and low bits 7..6 drop
    row_t rows [6] = '{'{8'h10, 8'hff, 8'hbf}, '{8'h11, 8'hff, 8'h3f},
        '{8'h12, 8'h8a, 8'h8a}, '{8'h13, 8'hc5, 8'h05},
        '{8'h14, 8'h60, 8'h20}, '{8'h15, 8'h55, 8'h00}};
    buck_voltage_select_regs uut (.mclk, .rst, .reg_req, .reg_rsp, .undervoltage_lockout,
        .buck2_select_pin, .buck3_select_pin, .nv_buck1_external_adjust(1'b1),
        .nv_buck2_external_adjust(nv_adj2), .nv_buck3_external_adjust(1'b1),
        .regulator2_follow_enable, .first_buck, .second_buck, .third_buck,
        .regulator2_follow_code, .regulator2_follow_active);
    host_model host (.mclk, .reg_rsp, .reg_req);
    // ****************************************
    // Helpers
    // ****************************************
    task chk(input logic [11:0] seen, input logic [11:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Three segments of the shared code table, in millivolts
    function automatic logic [11:0] mv(input logic [5:0] c);
        if (c < 6'h20) return 12'h2d5 + 12'(c) * 12'h019;
        if (c < 6'h3c) return 12'h60e + 12'(c - 6'h20) * 12'h032;
        return 12'hbb8 + 12'(c - 6'h3c) * 12'h064;
    endfunction
    task wait_n(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task results;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial forever #2.5 mclk = ~mclk;
    // Hang guard, well above the few hundred cycles the run needs
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_errors++;
            results;
        end
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (12) @(posedge mclk);
        @(negedge mclk) rst = 1'b0;
        wait_n(3);
        foreach (dflt[i]) begin
            host.rd(8'h10 + 8'(i), rdat);
            chk(rdat, dflt[i]);
        end
        $display("test defaults done");
        foreach (rows[i]) begin
            host.wr(rows[i].a, rows[i].d);
            host.rd(rows[i].a, rdat);
            chk(rdat, rows[i].r);
        end
        wait_n(2);
        chk(first_buck.code, 12'h03f);
        chk(first_buck.ext_adjust, 12'h001);
        chk(second_buck.code, 12'h03f);
        chk(second_buck.ext_adjust, 12'h001);
        chk(third_buck.millivolts, 12'h352);
        $display("test table done");
        buck2_select_pin = 1'b1;
        buck3_select_pin = 1'b1;
        wait_n(6);
        chk(second_buck.code, 12'h00a);
        chk(second_buck.millivolts, 12'h3cf);
        chk(third_buck.millivolts, 12'h60e);
        buck3_select_pin = 1'b0;
        regulator2_follow_enable = 1'b1;
        wait_n(6);
        chk(third_buck.code, 12'h005);
        chk(regulator2_follow_code, 12'h005);
        buck3_select_pin = 1'b1;
        wait_n(6);
        chk(regulator2_follow_code, 12'h020);
        regulator2_follow_enable = 1'b0;
        wait_n(3);
        chk(regulator2_follow_code, 12'h000);
        $display("test pins done");
        for (int c = 0; c < 64; c++) begin
            host.wr(8'h10, 8'(c));
            wait_n(2);
            chk(first_buck.millivolts, mv(6'(c)));
        end
        chk(first_buck.ext_adjust, 12'h000);
        $display("test table sweep done");
        // Nonvolatile bit flipped so a constant default would be caught
        nv_adj2 = 1'b1;
        undervoltage_lockout = 1'b1;
        wait_n(6);
        host.wr(8'h12, 8'h01);
        undervoltage_lockout = 1'b0;
        wait_n(6);
        host.rd(8'h10, rdat);
        chk(rdat, 12'h0bf);
        host.rd(8'h12, rdat);
        chk(rdat, 12'h0bf);
        host.rd(8'h14, rdat);
        chk(rdat, 12'h093);
        $display("test lockout done");
        // Reset in mid-run clears outputs and brings the defaults back
        host.wr(8'h11, 8'h01);
        @(negedge mclk) rst = 1'b1;
        wait_n(2);
        chk(second_buck.millivolts, 12'h000);
        rst = 1'b0;
        wait_n(3);
        host.rd(8'h11, rdat);
        chk(rdat, 12'h025);
        $display("test reset done");
        results;
    end
endmodule // tb_top

bind buck_voltage_select_regs buck_vsel_sva chk_i (.mclk, .rst, .reg_req, .reg_rsp,
    .undervoltage_lockout, .buck2_select_pin, .buck3_select_pin, .regulator2_follow_enable,
    .first_buck, .second_buck, .third_buck, .regulator2_follow_code, .regulator2_follow_active);
